// [rtl/pmcs_defs.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the PLL config/status block
// Assumes: 250 MHz system clock, 8-bit register port
// Notes: Definitions only
`ifndef PMCS_DEFS_SVH
`define PMCS_DEFS_SVH

`define PMCS_OFS_BAND_CTRL 8'h12
`define PMCS_OFS_LOOP_TUNING 8'h14
`define PMCS_OFS_DIV_SETUP 8'h15
`define PMCS_OFS_LOCK_STATUS 8'h16
`define PMCS_OFS_BAND_STATUS 8'h17

`define PMCS_RST_BAND_CTRL 8'h00
`define PMCS_RST_LOOP_TUNING 8'hE7
`define PMCS_RST_DIV_SETUP 8'hC9

`define PMCS_POS_ENABLE 7
`define PMCS_POS_MANUAL 6
`define PMCS_POS_BAND_HI 5
`define PMCS_POS_BW_HI 7
`define PMCS_POS_BW_LO 5
`define PMCS_POS_CP_HI 4
`define PMCS_POS_CP_LO 0
`define PMCS_POS_LOGDIV_HI 7
`define PMCS_POS_LOGDIV_LO 6
`define PMCS_POS_XPT_EN 4
`define PMCS_POS_OSCDIV_HI 3
`define PMCS_POS_OSCDIV_LO 2
`define PMCS_POS_LOOPDIV_HI 1
`define PMCS_POS_LOOPDIV_LO 0
`define PMCS_POS_LOCK 7
`define PMCS_POS_TUNE_HI 3

`define PMCS_CLK_PERIOD_PS 4000
`define PMCS_LOCK_SETTLE_NS 1000
`define PMCS_LOCK_SETTLE_CYC ((`PMCS_LOCK_SETTLE_NS * 1000 + `PMCS_CLK_PERIOD_PS - 1) / `PMCS_CLK_PERIOD_PS)

`endif

// [rtl/pmcs_pkg.sv]
// Purpose: Types shared by the PLL config/status block
// Assumes: Nothing beyond the defs header
// Notes: Calibration states Gray coded along idle, run, done
package pmcs_pkg;
  typedef enum logic [1:0] {
    PMCS_CAL_IDLE = 2'h0,
    PMCS_CAL_RUN = 2'h1,
    PMCS_CAL_DONE = 2'h3
  } pmcs_cal_state_t;
endpackage

// [rtl/pmcs_pll_regs.sv]
// Purpose: Register file, band selection sequencing and lock qualification of the clock-multiplier PLL
// Assumes: Analog status inputs are asynchronous to clk and are double-registered before use
// Notes: Overview of operation
// Overview of operation
// - Loop bandwidth field bits 7:5 of loop tuning register, reset 0x7.
// - Charge pump field bits 4:0 of loop tuning register, reset 0x07.
// - Logic clock divider code 00..11 divides reference by 2,4,8,16; reset 0x3.
// - Loop divider crosspoint enable bit 4, reset 0.
// - Oscillator divider code 00,01,10,11 gives 1,2,4,4; reset 0x2.
// - Feedback divider code 00..11 gives 2,4,8,16; reset 0x1.
// - Read-only lock bit 7 of first status register, reset 0.
// - Tuning voltage reported as four-bit read-only binary code.
// - Locked loop: higher band lowers tuning code, lower band raises it.
// - Band in use reported as six-bit read-only field, reset zero.
// - Multiplier enable bit 7 of band control register, reset off.
// - Mode bit 6: 0 automatic band selection, 1 manual.
// - Manual band value selects one of 64 bands, 0 lowest.
`timescale 1ns/10ps
`include "pmcs_defs.svh"

module pmcs_pll_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ana_lock,
  input wire logic [3:0] ana_tune_code,
  input wire logic ana_cal_done,
  input wire logic [5:0] ana_cal_band,
  output logic pll_enable,
  output logic band_manual,
  output logic [5:0] band_select,
  output logic cal_start,
  output logic [2:0] loop_filter_bandwidth,
  output logic [4:0] charge_pump_setting,
  output logic crosspoint_enable,
  output logic [4:0] logic_clock_ratio,
  output logic [2:0] oscillator_ratio,
  output logic [4:0] loop_ratio
);
  import pmcs_pkg::*;

  localparam logic [8:0] SETTLE_CYC = 9'(`PMCS_LOCK_SETTLE_CYC);

  logic [7:0] band_ctrl_r, band_ctrl_nxt;
  logic [7:0] loop_tuning_r, loop_tuning_nxt;
  logic [7:0] div_setup_r, div_setup_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Two-stage synchronisers; stage one feeds only stage two
  logic [11:0] sync1_r, sync2_r;
  logic [11:0] async_in;
  logic lock_s, cal_done_s;
  logic [3:0] tune_s;
  logic [5:0] cal_band_s;

  pmcs_cal_state_t cal_state_r, cal_state_nxt;
  logic [5:0] auto_band_r, auto_band_nxt;
  logic [5:0] band_rb_r, band_rb_nxt;
  logic cal_start_r, cal_start_nxt;
  logic [8:0] settle_r, settle_nxt;
  logic lock_r, lock_nxt;
  logic [3:0] tune_r, tune_nxt;
  logic [5:0] band_sel_r, band_sel_nxt;
  logic [4:0] log_ratio_r, log_ratio_nxt;
  logic [2:0] osc_ratio_r, osc_ratio_nxt;
  logic [4:0] loop_ratio_r, loop_ratio_nxt;
  logic manual_mode;
  logic enabled;

  assign async_in = {ana_lock, ana_cal_done, ana_tune_code, ana_cal_band};
  assign lock_s = sync2_r[11];
  assign cal_done_s = sync2_r[10];
  assign tune_s = sync2_r[9:6];
  assign cal_band_s = sync2_r[5:0];
  assign enabled = band_ctrl_r[`PMCS_POS_ENABLE];
  assign manual_mode = band_ctrl_r[`PMCS_POS_MANUAL];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  // Register writes and readback
  always_comb begin
    band_ctrl_nxt = band_ctrl_r;
    loop_tuning_nxt = loop_tuning_r;
    div_setup_nxt = div_setup_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      unique case (reg_addr)
        `PMCS_OFS_BAND_CTRL: band_ctrl_nxt = reg_wdata;
        `PMCS_OFS_LOOP_TUNING: loop_tuning_nxt = reg_wdata;
        `PMCS_OFS_DIV_SETUP: div_setup_nxt = {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PMCS_OFS_BAND_CTRL: rdata_nxt = band_ctrl_r;
        `PMCS_OFS_LOOP_TUNING: rdata_nxt = loop_tuning_r;
        `PMCS_OFS_DIV_SETUP: rdata_nxt = div_setup_r;
        `PMCS_OFS_LOCK_STATUS: rdata_nxt = {lock_r, 3'h0, tune_r};
        `PMCS_OFS_BAND_STATUS: rdata_nxt = {2'h0, band_rb_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      band_ctrl_r <= `PMCS_RST_BAND_CTRL;
      loop_tuning_r <= `PMCS_RST_LOOP_TUNING;
      div_setup_r <= `PMCS_RST_DIV_SETUP;
      rdata_r <= 8'h00;
    end else begin
      band_ctrl_r <= band_ctrl_nxt;
      loop_tuning_r <= loop_tuning_nxt;
      div_setup_r <= div_setup_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Divider decodes; the 75 MHz ceiling on the logic clock is left to software
  always_comb begin
    unique case (div_setup_r[`PMCS_POS_LOGDIV_HI:`PMCS_POS_LOGDIV_LO])
      2'h0: log_ratio_nxt = 5'h02;
      2'h1: log_ratio_nxt = 5'h04;
      2'h2: log_ratio_nxt = 5'h08;
      2'h3: log_ratio_nxt = 5'h10;
    endcase
    unique case (div_setup_r[`PMCS_POS_OSCDIV_HI:`PMCS_POS_OSCDIV_LO])
      2'h0: osc_ratio_nxt = 3'h1;
      2'h1: osc_ratio_nxt = 3'h2;
      2'h2, 2'h3: osc_ratio_nxt = 3'h4;
    endcase
    unique case (div_setup_r[`PMCS_POS_LOOPDIV_HI:`PMCS_POS_LOOPDIV_LO])
      2'h0: loop_ratio_nxt = 5'h02;
      2'h1: loop_ratio_nxt = 5'h04;
      2'h2: loop_ratio_nxt = 5'h08;
      2'h3: loop_ratio_nxt = 5'h10;
    endcase
  end

  // Band selection: manual value drives the band; auto mode runs one calibration per enable
  always_comb begin
    cal_state_nxt = cal_state_r;
    auto_band_nxt = auto_band_r;
    cal_start_nxt = 1'b0;
    if (!enabled || manual_mode) begin
      cal_state_nxt = PMCS_CAL_IDLE;
    end else begin
      unique case (cal_state_r)
        PMCS_CAL_IDLE: begin
          cal_state_nxt = PMCS_CAL_RUN;
          cal_start_nxt = 1'b1;
        end
        PMCS_CAL_RUN: begin
          if (cal_done_s && !cal_start_r) begin
            cal_state_nxt = PMCS_CAL_DONE;
            auto_band_nxt = cal_band_s;
          end
        end
        PMCS_CAL_DONE: ;
        default: cal_state_nxt = PMCS_CAL_IDLE;
      endcase
    end
    band_sel_nxt = manual_mode ? band_ctrl_r[`PMCS_POS_BAND_HI:0] : auto_band_r;
    band_rb_nxt = band_sel_r;
    // The tuning code follows the analog loop, so a band change moves it the documented way
    tune_nxt = tune_s;
  end

  // Lock must hold for the settle time before it is reported
  always_comb begin
    settle_nxt = settle_r;
    lock_nxt = lock_r;
    if (!enabled || !lock_s) begin
      settle_nxt = 9'h000;
      lock_nxt = 1'b0;
    end else if (settle_r < SETTLE_CYC) begin
      settle_nxt = settle_r + 9'h001;
    end else begin
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_state_r <= PMCS_CAL_IDLE;
      auto_band_r <= 6'h00;
      band_rb_r <= 6'h00;
      band_sel_r <= 6'h00;
      cal_start_r <= 1'b0;
      settle_r <= 9'h000;
      lock_r <= 1'b0;
      tune_r <= 4'h0;
      log_ratio_r <= 5'h10;
      osc_ratio_r <= 3'h4;
      loop_ratio_r <= 5'h04;
    end else begin
      cal_state_r <= cal_state_nxt;
      auto_band_r <= auto_band_nxt;
      band_rb_r <= band_rb_nxt;
      band_sel_r <= band_sel_nxt;
      cal_start_r <= cal_start_nxt;
      settle_r <= settle_nxt;
      lock_r <= lock_nxt;
      tune_r <= tune_nxt;
      log_ratio_r <= log_ratio_nxt;
      osc_ratio_r <= osc_ratio_nxt;
      loop_ratio_r <= loop_ratio_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign pll_enable = band_ctrl_r[`PMCS_POS_ENABLE];
  assign band_manual = band_ctrl_r[`PMCS_POS_MANUAL];
  assign band_select = band_sel_r;
  assign cal_start = cal_start_r;
  assign loop_filter_bandwidth = loop_tuning_r[`PMCS_POS_BW_HI:`PMCS_POS_BW_LO];
  assign charge_pump_setting = loop_tuning_r[`PMCS_POS_CP_HI:`PMCS_POS_CP_LO];
  assign crosspoint_enable = div_setup_r[`PMCS_POS_XPT_EN];
  assign logic_clock_ratio = log_ratio_r;
  assign oscillator_ratio = osc_ratio_r;
  assign loop_ratio = loop_ratio_r;
endmodule // pmcs_pll_regs

// [bench/pmcs_chk.sv]
// Purpose: Port assertions for the PLL config/status registers
// Assumes: Decode checks skip a second write to 0x15 or 0x12 on the next cycle
// Notes: Bound to every instance of pmcs_pll_regs
`timescale 1ns/10ps
module pmcs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pll_enable,
  input wire logic band_manual,
  input wire logic [5:0] band_select,
  input wire logic cal_start,
  input wire logic [2:0] loop_filter_bandwidth,
  input wire logic [4:0] charge_pump_setting,
  input wire logic crosspoint_enable,
  input wire logic [4:0] logic_clock_ratio,
  input wire logic [2:0] oscillator_ratio,
  input wire logic [4:0] loop_ratio
);
  logic w12, w14, w15;
  assign w12 = reg_wr && reg_addr == 8'h12;
  assign w14 = reg_wr && reg_addr == 8'h14;
  assign w15 = reg_wr && reg_addr == 8'h15;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_bw_cp_write:
  assert property (w14 |=> {loop_filter_bandwidth, charge_pump_setting} == $past(reg_wdata))
    else $error("loop tuning fields wrong");
  chk_logic_div:
  assert property (w15 ##1 !w15 |=> logic_clock_ratio == 5'h02 << $past(reg_wdata[7:6], 2))
    else $error("logic ratio wrong");
  chk_osc_div:
  assert property (w15 ##1 !w15 |=> oscillator_ratio == ($past(reg_wdata[3], 2) ? 3'h4 :
    3'h1 << $past(reg_wdata[2], 2))) else $error("osc ratio wrong");
  chk_loop_div:
  assert property (w15 ##1 !w15 |=> loop_ratio == 5'h02 << $past(reg_wdata[1:0], 2))
    else $error("loop ratio wrong");
  chk_xpt_write:
  assert property (w15 |=> crosspoint_enable == $past(reg_wdata[4])) else $error("xpt wrong");
  chk_enable_mode:
  assert property (w12 |=> {pll_enable, band_manual} == $past(reg_wdata[7:6]))
    else $error("enable or mode wrong");
  chk_manual_band:
  assert property (w12 && reg_wdata[6] ##1 !w12 |=> band_select == $past(reg_wdata[5:0], 2))
    else $error("manual band wrong");
  chk_cal_launch:
  assert property ($rose(pll_enable) && !band_manual |=> cal_start ##1 !cal_start)
    else $error("no single calibration pulse");
  chk_lock_off:
  assert property (reg_rd && reg_addr == 8'h16 && !pll_enable && !$past(pll_enable)
    |=> !reg_rdata[7]) else $error("lock while disabled");
endmodule // pmcs_chk
bind pmcs_pll_regs pmcs_chk i_chk (.*);

// [bench/tb_pmcs_pll_regs.sv]
// Purpose: Directed register and lock tests of the PLL config/status block
// Assumes: Analog inputs are driven as slow levels
// Notes: Lock settle is the fixed 250-cycle count, so waits bracket it
`timescale 1ns/10ps
module tb_pmcs_pll_regs;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ana_lock = 0, ana_cal_done = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [3:0] ana_tune_code = 0;
  logic [5:0] ana_cal_band = 0, band_select;
  logic pll_enable, band_manual, cal_start, crosspoint_enable;
  logic [2:0] loop_filter_bandwidth, oscillator_ratio;
  logic [4:0] charge_pump_setting, logic_clock_ratio, loop_ratio;
  int errors = 0, checks = 0;
  always #2 clk = ~clk;
  pmcs_pll_regs i_dut (.*);
  task automatic cmp(input logic [7:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 cmp(reg_rdata, e, "read");
  endtask
  task automatic t_reset;
    rd(8'h12, 8'h00);
    rd(8'h14, 8'hE7);
    rd(8'h15, 8'hC9);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    cmp({logic_clock_ratio, oscillator_ratio}, 8'h84, "ratios");
    cmp({loop_filter_bandwidth, charge_pump_setting}, 8'hE7, "bw cp rst");
    cmp({pll_enable, band_manual, crosspoint_enable, loop_ratio}, 8'h04, "ctl rst");
    cmp({cal_start, 1'b0, band_select}, 8'h00, "band rst");
    $display("t_reset end");
  endtask
  task automatic t_div;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      // Bit 5 written high must read back low
      // Fast logic-clock codes assume a reference slow enough for the logic clock limit
      wr(8'h15, {c, 2'b11, c, c});
      rd(8'h15, {c, 2'b01, c, c});
      cmp({3'h0, logic_clock_ratio}, 8'h02 << c, "logic");
      cmp({5'h0, oscillator_ratio}, c[1] ? 8'h04 : 8'h01 << c, "osc");
      cmp({3'h0, loop_ratio}, 8'h02 << c, "loop");
    end
    wr(8'h14, 8'h5A);
    rd(8'h14, 8'h5A);
    cmp({loop_filter_bandwidth, charge_pump_setting}, 8'h5A, "bw cp");
    cmp({7'h0, crosspoint_enable}, 8'h01, "xpt");
    $display("t_div end");
  endtask
  task automatic t_ro;
    wr(8'h16, 8'hFF);
    wr(8'h17, 8'hFF);
    wr(8'h30, 8'hAA);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h30, 8'h00);
    $display("t_ro end");
  endtask
  task automatic t_manual;
    logic [5:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 6'h15 * 6'(i);
      wr(8'h12, {2'b11, b});
      repeat (2) @(posedge clk);
      #1 cmp({2'b00, band_select}, {2'b00, b}, "band");
      cmp({6'h0, pll_enable, band_manual}, 8'h03, "enable mode");
      rd(8'h17, {2'b00, b});
    end
    $display("t_manual end");
  endtask
  task automatic t_lock;
    logic seen;
    // Analog levels change only on a rising edge, never just after a compare
    @(posedge clk);
    ana_cal_band <= 6'h2A;
    ana_tune_code <= 4'h7;
    wr(8'h12, 8'h00);
    wr(8'h12, 8'h80);
    seen = 0;
    repeat (6) begin
      @(posedge clk);
      #1 seen |= cal_start;
    end
    cmp({7'h0, seen}, 8'h01, "cal start");
    @(posedge clk);
    ana_cal_done <= 1;
    repeat (6) @(posedge clk);
    rd(8'h17, 8'h2A);
    @(posedge clk);
    ana_lock <= 1;
    // Settling needs about 253 cycles after lock rises
    repeat (200) @(posedge clk);
    rd(8'h16, 8'h07);
    repeat (100) @(posedge clk);
    rd(8'h16, 8'h87);
    @(posedge clk);
    ana_lock <= 0;
    repeat (6) @(posedge clk);
    rd(8'h16, 8'h07);
    @(posedge clk);
    ana_lock <= 1;
    ana_tune_code <= 4'hA;
    repeat (300) @(posedge clk);
    rd(8'h16, 8'h8A);
    wr(8'h12, 8'h00);
    rd(8'h16, 8'h0A);
    $display("t_lock end");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 0;
    t_reset; t_div; t_ro; t_manual; t_lock;
    report_and_stop;
  end
endmodule // tb_pmcs_pll_regs
